// ---- rtl/fp_format_pkg.sv ----
// Purpose: shared constants for the operand format unit
// Assumes: customary binary float layouts, operands passed in by the host
// Notes: fields are right-justified in 64-bit words
package fp_format_pkg;
  // operand widths
  localparam int SGL_WIDTH = 32;
  localparam int DBL_WIDTH = 64;
  // single precision field layout
  localparam int SGL_SIGN_POS = 31;
  localparam int SGL_EXP_WIDTH = 8;
  localparam int SGL_FRAC_WIDTH = 23;
  localparam logic [10:0] SGL_BIAS = 11'h07F;
  // double precision field layout
  localparam int DBL_SIGN_POS = 63;
  localparam int DBL_EXP_WIDTH = 11;
  localparam int DBL_FRAC_WIDTH = 52;
  localparam logic [10:0] DBL_BIAS = 11'h3FF;
  // integer sizes
  localparam int INT_BYTE_WIDTH = 8;
  localparam int INT_WORD_WIDTH = 16;
  localparam int INT_DWORD_WIDTH = 32;
  // trap type codes
  localparam logic [2:0] TRAP_NONE = 3'h0;
  localparam logic [2:0] TRAP_INVALID = 3'h5;
  // operand format selects
  typedef enum logic [2:0] {
    FMT_SHORT_FLOAT,
    FMT_LONG_FLOAT,
    FMT_INT_BYTE,
    FMT_INT_WORD,
    FMT_INT_DWORD
  } format_type;
  // operand classes
  typedef enum logic [1:0] {
    CLASS_NORMAL,
    CLASS_ZERO,
    CLASS_RESERVED
  } class_type;
endpackage : fp_format_pkg

// ---- rtl/fp_field_if.sv ----
// Purpose: carries one operand and its unpacked fields between modules
// Assumes: one clock domain
// Notes: the splitter drives fields, the top reads them
`timescale 1ns/10ps
`default_nettype none
interface fp_field_if;
  logic [63:0] word;
  fp_format_pkg::format_type fmt;
  logic sign;
  logic [10:0] exp_field;
  logic [52:0] significand;
  logic signed [12:0] true_exp;
  fp_format_pkg::class_type op_class;
  logic signed [63:0] int_value;
  modport splitter (input word, input fmt, output sign, output exp_field, output significand,
    output true_exp, output op_class, output int_value);
  modport user (output word, output fmt, input sign, input exp_field, input significand,
    input true_exp, input op_class, input int_value);
endinterface : fp_field_if
`default_nettype wire

// ---- rtl/fp_field_splitter.sv ----
// Purpose: combinational split and classify of one operand
// Assumes: operand right-justified in a 64-bit word
// Notes: no state; the top registers the results
`timescale 1ns/10ps
`default_nettype none
module fp_field_splitter (
  fp_field_if.splitter ops
);
  // ----------------------------------------
  // raw field selection per precision
  // ----------------------------------------
  wire logic is_dbl = (ops.fmt == fp_format_pkg::FMT_LONG_FLOAT);
  wire logic [7:0] sgl_exp = ops.word[30:23];
  wire logic [22:0] sgl_frac = ops.word[22:0];
  wire logic [10:0] dbl_exp = ops.word[62:52];
  wire logic [51:0] dbl_frac = ops.word[51:0];
  wire logic [10:0] exp_raw = is_dbl ? dbl_exp : {3'h0, sgl_exp};
  wire logic [51:0] frac_raw = is_dbl ? dbl_frac : {sgl_frac, 29'h0};
  wire logic exp_ones = is_dbl ? (&dbl_exp) : (&sgl_exp);
  wire logic exp_zero = (exp_raw == 11'h000);
  wire logic frac_zero = (frac_raw == 52'h0);
  wire logic [10:0] bias = is_dbl ? fp_format_pkg::DBL_BIAS : fp_format_pkg::SGL_BIAS;
  wire logic is_float = is_dbl || (ops.fmt == fp_format_pkg::FMT_SHORT_FLOAT);
  // ----------------------------------------
  // field outputs
  // ----------------------------------------
  // sign-magnitude: 1 means negative
  assign ops.sign = is_dbl ? ops.word[63] : ops.word[31];
  assign ops.exp_field = exp_raw;
  // hidden one whenever the exponent field is nonzero, all-ones included
  assign ops.significand = {!exp_zero, frac_raw};
  assign ops.true_exp = $signed({2'b00, exp_raw}) - $signed({2'b00, bias});
  // classification: ones reserved, zero/zero is zero, zero/nonzero reserved
  assign ops.op_class = !is_float ? fp_format_pkg::CLASS_NORMAL :
    exp_ones ? fp_format_pkg::CLASS_RESERVED :
    (exp_zero && frac_zero) ? fp_format_pkg::CLASS_ZERO :
    exp_zero ? fp_format_pkg::CLASS_RESERVED : fp_format_pkg::CLASS_NORMAL;
  // two's complement integers sign-extended
  assign ops.int_value = (ops.fmt == fp_format_pkg::FMT_INT_BYTE) ?
    {{56{ops.word[7]}}, ops.word[7:0]} :
    (ops.fmt == fp_format_pkg::FMT_INT_WORD) ? {{48{ops.word[15]}}, ops.word[15:0]} :
    {{32{ops.word[31]}}, ops.word[31:0]};
endmodule : fp_field_splitter
`default_nettype wire

// ---- rtl/fp_operand_format_classifier.sv ----
// What this block does
// - single is 32 bits, double 64 bits
// - format select picks short or long float
// - normalized significand gets hidden leading one
// - true exponent is field minus 127/1023
// - all-ones exponent means reserved operand
// - zero exponent: zero fraction zero, else reserved
// - normalized only when exponent not zeros/ones
// - sign bit 0 positive, 1 negative
// - negate flips only the sign bit
// - both signed zeros recognised as zero
// - reserved input traps unless plain move
// - never output infinity, not-a-number or denormal, except that a plain move passes them through
// - integers of 8, 16, 32 bits, two's complement
// - no memory access; host passes all operands
// - invalid operation sets trap type 101
//
// Purpose: operand format and classification unit of a float coprocessor
// Assumes: host delivers whole operands already in low-byte-first order
// Notes: one-cycle registered result per accepted request
`timescale 1ns/10ps
`default_nettype none
module fp_operand_format_classifier (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic op_valid_in,
  input wire fp_format_pkg::format_type op_fmt_in,
  input wire logic [63:0] op_a_in,
  input wire logic [63:0] op_b_in,
  input wire logic op_b_used_in,
  input wire logic move_only_in,
  input wire logic negate_in,
  input wire logic div_in,
  output logic res_valid_out,
  output logic [63:0] res_word_out,
  output logic res_sign_out,
  output logic [10:0] res_exp_out,
  output logic [52:0] res_sig_out,
  output logic signed [12:0] res_true_exp_out,
  output fp_format_pkg::class_type res_class_a_out,
  output fp_format_pkg::class_type res_class_b_out,
  output logic signed [63:0] res_int_out,
  output logic invalid_out,
  output logic trap_req_out,
  output logic [2:0] trap_type_out
);
  // ----------------------------------------
  // operand splitters
  // ----------------------------------------
  fp_field_if a_if ();
  fp_field_if b_if ();
  assign a_if.word = op_a_in;
  assign a_if.fmt = op_fmt_in;
  assign b_if.word = op_b_in;
  assign b_if.fmt = op_fmt_in;
  fp_field_splitter split_a (
    .ops(a_if)
  );
  fp_field_splitter split_b (
    .ops(b_if)
  );
  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic is_dbl = (op_fmt_in == fp_format_pkg::FMT_LONG_FLOAT);
  wire logic is_float = is_dbl || (op_fmt_in == fp_format_pkg::FMT_SHORT_FLOAT);
  wire logic a_res = (a_if.op_class == fp_format_pkg::CLASS_RESERVED);
  wire logic b_res = op_b_used_in && (b_if.op_class == fp_format_pkg::CLASS_RESERVED);
  wire logic zero_div = div_in && op_b_used_in && is_float &&
    (a_if.op_class == fp_format_pkg::CLASS_ZERO) && (b_if.op_class == fp_format_pkg::CLASS_ZERO);
  wire logic bad_in = is_float && (a_res || b_res) && !move_only_in;
  wire logic invalid_d = bad_in || zero_div;
  // sign position per width
  wire logic [63:0] sign_mask = is_dbl ? 64'h8000_0000_0000_0000 : 64'h0000_0000_8000_0000;
  wire logic [63:0] width_mask = is_dbl ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
  wire logic do_neg = negate_in && is_float && !a_res;
  wire logic [63:0] word_d = (op_a_in & width_mask) ^ (do_neg ? sign_mask : 64'h0);
  // reserved results suppressed unless a plain move passes them through
  wire logic out_bad = a_res && !move_only_in;
  wire logic [63:0] res_word_d = out_bad ? 64'h0 : word_d;
  wire logic [2:0] ttype_d = invalid_d ? fp_format_pkg::TRAP_INVALID : fp_format_pkg::TRAP_NONE;
  // ----------------------------------------
  // result registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_valid_out <= 1'b0;
      res_word_out <= 64'h0;
      res_sign_out <= 1'b0;
      res_exp_out <= 11'h0;
      res_sig_out <= 53'h0;
      res_true_exp_out <= 13'h0;
      res_class_a_out <= fp_format_pkg::CLASS_ZERO;
      res_class_b_out <= fp_format_pkg::CLASS_ZERO;
      res_int_out <= 64'h0;
      invalid_out <= 1'b0;
      trap_req_out <= 1'b0;
      trap_type_out <= fp_format_pkg::TRAP_NONE;
    end else begin
      res_valid_out <= op_valid_in;
      if (op_valid_in) begin
        res_word_out <= res_word_d;
        res_sign_out <= a_if.sign ^ do_neg;
        res_exp_out <= a_if.exp_field;
        res_sig_out <= a_if.significand;
        res_true_exp_out <= a_if.true_exp;
        res_class_a_out <= a_if.op_class;
        res_class_b_out <= b_if.op_class;
        res_int_out <= a_if.int_value;
        invalid_out <= invalid_d;
        trap_req_out <= invalid_d;
        trap_type_out <= ttype_d;
      end
    end
  end
endmodule : fp_operand_format_classifier
`default_nettype wire

// ---- tb/fp_operand_format_classifier_chk.sv ----
// Purpose: port-level checks of the operand format unit
// Assumes: one clock domain, async active-low reset
// Notes: bound onto the top module below
`timescale 1ns/10ps
`default_nettype none
module fp_format_chk (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic op_valid_in,
  input wire fp_format_pkg::format_type op_fmt_in,
  input wire logic [63:0] op_a_in,
  input wire logic res_valid_out,
  input wire logic [10:0] res_exp_out,
  input wire logic [52:0] res_sig_out,
  input wire logic signed [12:0] res_true_exp_out,
  input wire fp_format_pkg::class_type res_class_a_out,
  input wire logic invalid_out,
  input wire logic trap_req_out,
  input wire logic [2:0] trap_type_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // a double precision request taken at this edge
  sequence dbl_req;
    op_valid_in && op_fmt_in == fp_format_pkg::FMT_LONG_FLOAT;
  endsequence
  pulse_after_req_a: assert property (op_valid_in |=> res_valid_out)
    else $error("missing result pulse");
  trap_code_a: assert property (invalid_out |-> trap_type_out == 3'h5)
    else $error("wrong trap code");
  trap_flag_a: assert property (trap_req_out == invalid_out)
    else $error("trap request differs from invalid");
  ones_reserved_a: assert property (dbl_req ##0 (&op_a_in[62:52]) |=>
    res_class_a_out == fp_format_pkg::CLASS_RESERVED) else $error("all-ones not reserved");
  zero_class_a: assert property (dbl_req ##0 (op_a_in[62:0] == 63'h0) |=>
    res_class_a_out == fp_format_pkg::CLASS_ZERO) else $error("signed zero missed");
  bias_dbl_a: assert property (dbl_req |=>
    res_true_exp_out == $signed({2'b00, res_exp_out}) - 13'sd1023) else $error("bad bias");
  hidden_one_a: assert property (dbl_req ##0 (op_a_in[62:52] != 11'h000) |=>
    res_sig_out[52]) else $error("hidden one missing");
  frac_field_a: assert property (dbl_req |=>
    res_sig_out[51:0] == $past(op_a_in[51:0])) else $error("fraction field moved");
endmodule : fp_format_chk
bind fp_operand_format_classifier fp_format_chk u_chk (.*);
`default_nettype wire

// ---- tb/fp_host_model.sv ----
// Purpose: host side that keeps operands in byte memory and hands them over
// Assumes: memory low byte first, immediates high byte first
// Notes: combinational round trip through the byte store
`timescale 1ns/10ps
`default_nettype none
module fp_host_model (
  input wire logic imm_in,
  input wire logic [63:0] value_in,
  output logic [63:0] word_out
);
  logic [7:0] mem [8];
  // store the bytes, then gather the whole operand back for the unit
  always_comb begin
    for (int k = 0; k < 8; k++) mem[k] = value_in[8*(imm_in ? 7-k : k) +: 8];
    for (int k = 0; k < 8; k++) word_out[8*k +: 8] = mem[imm_in ? 7-k : k];
  end
endmodule : fp_host_model
`default_nettype wire

// ---- tb/tb_fp_operand_format_classifier.sv ----
// Purpose: self-checking bench for the operand format unit
// Assumes: integer model gives every expectation
// Notes: results compared at each res_valid_out pulse
`timescale 1ns/10ps
`default_nettype none
module tb_fp_operand_format_classifier;
  typedef struct packed {logic [63:0] w, i; logic [12:0] t; logic [1:0] ca, cb; logic inv, s;} exp_type;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, op_valid_in = 1'b0, op_b_used_in = 1'b0;
  logic move_only_in = 1'b0, negate_in = 1'b0, div_in = 1'b0, imm = 1'b0;
  logic [63:0] a_val = 64'h0, op_a_in, op_b_in = 64'h0, res_word_out;
  fp_format_pkg::format_type op_fmt_in = fp_format_pkg::FMT_SHORT_FLOAT;
  logic res_valid_out, res_sign_out, invalid_out, trap_req_out;
  logic [10:0] res_exp_out;
  logic [52:0] res_sig_out;
  logic signed [12:0] res_true_exp_out;
  fp_format_pkg::class_type res_class_a_out, res_class_b_out;
  logic signed [63:0] res_int_out;
  logic [2:0] trap_type_out;
  int n_fail = 0, total_checks = 0;
  exp_type q[$];
  exp_type e;
  logic [63:0] d [8] = '{64'h3F800000, 64'h7F800000, 64'h80000000, 64'h1, 64'h3FF8000000000000,
    64'h7FF0000000000001, 64'h8000000000000000, 64'hFFFFFFFFFFFFF};
  logic [3:0] md [5] = '{4'h0, 4'h4, 4'hA, 4'h9, 4'h5};
  fp_operand_format_classifier u_dut (.*);
  fp_host_model u_host (.imm_in(imm), .value_in(a_val), .word_out(op_a_in));
  initial forever #4 clk_sys_in = ~clk_sys_in;
  // class of one operand: 2 reserved, 1 zero, 0 normal
  function automatic logic [1:0] cls(input int f, input logic [63:0] x);
    logic o, z, n;
    o = f ? &x[62:52] : &x[30:23];
    n = f ? x[62:52] == 0 : x[30:23] == 0;
    z = f ? x[62:0] == 0 : x[30:0] == 0;
    if (f > 1) return 2'h0;
    return (o || (n && !z)) ? 2'h2 : z ? 2'h1 : 2'h0;
  endfunction : cls
  task automatic chk(input logic [63:0] g, x);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, g, x);
    end
  endtask : chk
  // drive one request and queue what it must produce
  task automatic send(input int f, input logic [63:0] a, b, input logic [3:0] m);
    exp_type x;
    int n;
    @(posedge clk_sys_in);
    op_valid_in <= 1'b1;
    op_fmt_in <= fp_format_pkg::format_type'(f);
    a_val <= a;
    op_b_in <= b;
    imm <= 1'($urandom);
    {op_b_used_in, move_only_in, negate_in, div_in} <= m;
    n = f == 1 ? 64 : 32;
    x.ca = cls(f, a);
    x.cb = cls(f, b);
    x.inv = (f < 2 && (x.ca == 2 || (m[3] && x.cb == 2)) && !m[2]) ||
      (m[0] && m[3] && x.ca == 1 && x.cb == 1);
    x.w = a & ((64'h1 << n) - 64'h1);
    if (x.ca == 2 && !m[2]) x.w = 64'h0;
    else if (m[1] && f < 2 && x.ca != 2) x.w[n-1] = ~x.w[n-1];
    x.s = a[n-1] ^ (m[1] && f < 2 && x.ca != 2);
    x.t = f == 1 ? 13'(a[62:52]) - 13'h3FF : 13'(a[30:23]) - 13'h07F;
    n = f == 2 ? 8 : f == 3 ? 16 : 32;
    x.i = 64'($signed(a << (64 - n)) >>> (64 - n));
    q.push_back(x);
  endtask : send
  // compare every result pulse against the queued model
  always @(posedge clk_sys_in) begin
    #1;
    if (res_valid_out === 1'b1) begin
      chk(64'(q.size() > 0), 64'h1);
      e = q.pop_front();
      chk(res_word_out, e.w);
      chk(res_int_out, e.i);
      chk(64'({res_class_a_out, res_class_b_out}), 64'({e.ca, e.cb}));
      chk(64'({trap_req_out, trap_type_out}), e.inv ? 64'hD : 64'h0);
      chk(64'({invalid_out, res_sign_out}), 64'({e.inv, e.s}));
      chk(64'({res_true_exp_out}), 64'(e.t));
    end
  end
  task automatic close_out;
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  initial begin
    int f;
    void'($urandom(32'h359E));
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (md[j]) for (int k = 0; k < 8; k++) send(k / 4, d[k], d[k], md[j]);
    for (int k = 0; k < 400; k++) begin
      f = $urandom % 5;
      if ($urandom % 4 == 0) begin
        @(posedge clk_sys_in);
        op_valid_in <= 1'b0;
      end
      send(f, {$urandom, $urandom}, {$urandom, $urandom}, 4'($urandom) & (f > 1 ? 4'hD : 4'hF));
    end
    @(posedge clk_sys_in);
    op_valid_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk(64'(q.size()), 64'h0);
    close_out();
  end
endmodule : tb_fp_operand_format_classifier
`default_nettype wire
